/* common/prog_link_pkg.sv */
// Constants and types for the sensor programming link controller
// Overview of operation
// RQ1 - Controller raises supply to program-enable high; device pin becomes data input.
// RQ2 - Controller drives data line low within program time delay after enable.
// RQ3 - After command, supply drops below program-enable low; device output resumes.
// RQ4 - Nonvolatile write commits in write delay; device signals completion with falling edge.
// RQ5 - Device ignores further pulses after first frame while enable stays high.
// RQ6 - Multiple commands need program enable dropped and raised between frames.
// RQ7 - Three connections: supply carries enable, output pin data, common ground.
// RQ8 - Four transactions: access code, volatile write, nonvolatile write, read.
// RQ9 - Each command frame opens with two-bit sync field valued 00.
// RQ10 - Direction bit follows sync: 0 is write, 1 is read.
// RQ11 - Six-bit register address follows the direction bit.
// RQ12 - Data field is thirty bits: twenty-four payload plus six correction.
// RQ13 - Read data: payload 23..0, correction status 25..24, 29..26 meaningless.
// RQ14 - Write data: payload in 23..0; device disregards bits 29..24.
// RQ15 - Each frame ends with a three-bit CRC field.
// RQ16 - Manchester bits, rising edge 0, falling edge 1, MSB first.
// RQ17 - Device never initiates; answers only reads with acknowledge frame.
// RQ18 - Controller never starts a command while a read acknowledge is in flight.
// RQ19 - Device discards frames failing CRC; polynomial is supplied separately. The device model checks no CRC and keeps every frame.
package prog_link_pkg;
    localparam int CLK_HZ          = 50_000_000;
    localparam int BIT_RATE        = 2000;
    localparam int HALF_BIT_CYC    = CLK_HZ / (2 * BIT_RATE);
    localparam int LOW_DELAY_NS    = 100_000;
    localparam int LOW_DELAY_CYC   = LOW_DELAY_NS / 20;
    localparam int PROG_DELAY_US   = 500;
    localparam int PROG_DELAY_CYC  = PROG_DELAY_US * 50;
    localparam int WRITE_DELAY_MS  = 20;
    localparam int WRITE_DELAY_CYC = WRITE_DELAY_MS * 50_000;
    localparam int SYNC_BITS       = 2;
    localparam int ADDR_BITS       = 6;
    localparam int DATA_BITS       = 30;
    localparam int PAYLOAD_BITS    = 24;
    localparam int CRC_BITS        = 3;
    localparam int FRAME_BITS      = SYNC_BITS + 1 + ADDR_BITS + DATA_BITS + CRC_BITS;
    localparam int ACK_BITS        = SYNC_BITS + DATA_BITS + CRC_BITS;
    localparam logic [1:0] SYNC_VAL = 2'h0;
    localparam logic       DIR_WR   = 1'b0;
    localparam logic       DIR_RD   = 1'b1;
    localparam logic [2:0] CRC_INIT = 3'h0;
    localparam logic [2:0] CRC_POLY = 3'h3;
    localparam int ECC_HI = 25;
    localparam int ECC_LO = 24;
    typedef enum logic [1:0] {
        CMD_ACCESS,
        CMD_VOL_WR,
        CMD_NV_WR,
        CMD_READ
    } cmd_t;
endpackage : prog_link_pkg

/* design/manchester_tx.sv */
// Manchester encoder for one bit at a time
`timescale 1ns/1ns
module manchester_tx #(
    parameter int HALF_BIT = prog_link_pkg::HALF_BIT_CYC
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Bit request
    input  wire logic start,
    input  wire logic bit_in,
    output logic      busy,
    output logic      done,
    // Line
    output logic      line
);
    import prog_link_pkg::*;
    logic [15:0] cnt;
    logic        half;
    logic        cur;
    // Next bit is taken on the last cycle of this one, so bit cells abut with no gap
    assign done = busy && half && (cnt == 16'h0000);
    // Rising edge is 0, falling edge is 1: first half is the bit's value
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            half <= 1'b0;
            cnt  <= 16'h0000;
            cur  <= 1'b0;
            line <= 1'b0;
        end else if (start && (!busy || done)) begin
            busy <= 1'b1;
            cur  <= bit_in;
            line <= bit_in;                // [RQ16]
            half <= 1'b0;
            cnt  <= 16'(HALF_BIT - 1);
        end else if (busy) begin
            if (cnt != 16'h0000) begin
                cnt <= cnt - 16'h0001;
            end else if (!half) begin
                half <= 1'b1;
                line <= ~cur;              // [RQ16]
                cnt  <= 16'(HALF_BIT - 1);
            end else begin
                busy <= 1'b0;
                line <= 1'b0;
            end
        end
    end
endmodule : manchester_tx

/* design/prog_link_host.sv */
// Programming controller that drives the sensor over supply and data pins
`timescale 1ns/1ns
module prog_link_host #(
    parameter int HALF_BIT    = prog_link_pkg::HALF_BIT_CYC,
    parameter int PROG_DELAY  = prog_link_pkg::PROG_DELAY_CYC,
    parameter int WRITE_DELAY = prog_link_pkg::WRITE_DELAY_CYC,
    parameter int ACK_TIMEOUT = 2 * prog_link_pkg::ACK_BITS * 2 * HALF_BIT
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    // Command port
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire prog_link_pkg::cmd_t  cmd_kind,
    input  wire logic [5:0]           cmd_addr,
    input  wire logic [23:0]          cmd_data,
    input  wire logic [2:0]           cmd_crc,
    // Result
    output logic                      rsp_valid,
    output logic [23:0]               rsp_data,
    output logic [1:0]                rsp_ecc,
    output logic [2:0]                rsp_crc,
    output logic                      rsp_timeout,
    // Supply switch
    output logic                      program_enable_high_level,
    // Data pin
    input  wire logic                 sensor_output_data_pin_in,
    output logic                      sensor_output_data_pin_out,
    output logic                      sensor_output_data_pin_oe
);
    import prog_link_pkg::*;
    typedef enum logic [2:0] {
        S_IDLE, S_ENABLE, S_SEND, S_WAIT_NV, S_RX, S_RELEASE
    } state_t;
    state_t       state;
    logic         rst_s1, rst_n;
    logic [FRAME_BITS-1:0] shreg;
    logic         ack_end;
    logic         guard_done;
    logic [5:0]   bitcnt;
    logic [31:0]  tmr;
    cmd_t         kind;
    logic         tx_start, tx_busy, tx_done, tx_line;
    logic         pin_d;
    logic [15:0]  rx_cnt;
    logic [34:0]  rx_sh;
    logic [5:0]   rx_n;
    logic         rx_armed;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end
    manchester_tx #(.HALF_BIT(HALF_BIT)) u_tx (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .start  (tx_start),
        .bit_in (shreg[FRAME_BITS-1]),
        .busy   (tx_busy),
        .done   (tx_done),
        .line   (tx_line)
    );
    assign cmd_ready = (state == S_IDLE);
    assign tx_start  = (state == S_SEND) && (bitcnt != 6'h00) && (!tx_busy || tx_done);
    // Main sequencer: one frame per enable period, enable dropped after each
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state                      <= S_IDLE;
            program_enable_high_level  <= 1'b0;
            sensor_output_data_pin_oe  <= 1'b0;
            shreg                      <= '0;
            bitcnt                     <= 6'h00;
            tmr                        <= 32'h0000_0000;
            kind                       <= CMD_ACCESS;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (cmd_valid) begin
                        kind  <= cmd_kind;
                        // [RQ9] [RQ10] [RQ11] [RQ12] [RQ14] [RQ15]
                        shreg <= {SYNC_VAL, (cmd_kind == CMD_READ) ? DIR_RD : DIR_WR, cmd_addr,
                                  6'h00, cmd_data, cmd_crc};
                        program_enable_high_level <= 1'b1;   // [RQ1] [RQ7]
                        sensor_output_data_pin_oe <= 1'b1;   // [RQ2]
                        tmr   <= 32'(LOW_DELAY_CYC);
                    end
                end
                S_ENABLE: begin
                    if (tmr != 32'h0000_0000) begin
                        tmr <= tmr - 32'h0000_0001;
                    end else begin
                        bitcnt <= 6'(FRAME_BITS);
                        state  <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (tx_start) begin
                        shreg  <= {shreg[FRAME_BITS-2:0], 1'b0};   // [RQ16]
                        bitcnt <= bitcnt - 6'h01;
                    end else if (tx_done) begin
                        sensor_output_data_pin_oe <= 1'b0;
                        if (kind == CMD_NV_WR) begin
                            tmr   <= 32'(WRITE_DELAY) + 32'(WRITE_DELAY / 2);
                            state <= S_WAIT_NV;
                        end else if (kind == CMD_READ) begin
                            tmr   <= 32'(ACK_TIMEOUT);
                            state <= S_RX;
                        end else begin
                            tmr   <= 32'(PROG_DELAY);
                            state <= S_RELEASE;
                        end
                    end
                end
                S_WAIT_NV: begin
                    // Completion is a high-to-low edge on the pin, once the released pin has settled
                    if ((guard_done && pin_d && !sensor_output_data_pin_in) || tmr == 32'h0000_0000) begin  // [RQ4]
                        tmr   <= 32'(PROG_DELAY);
                        state <= S_RELEASE;
                    end else begin
                        tmr <= tmr - 32'h0000_0001;
                    end
                end
                S_RX: begin
                    // No new frame while the acknowledge is still arriving
                    if (ack_end || tmr == 32'h0000_0000) begin  // [RQ18] [RQ17]
                        tmr   <= 32'(PROG_DELAY);
                        state <= S_RELEASE;
                    end else begin
                        tmr <= tmr - 32'h0000_0001;
                    end
                end
                S_RELEASE: begin
                    program_enable_high_level <= 1'b0;       // [RQ3] [RQ6] [RQ5]
                    if (tmr != 32'h0000_0000) begin
                        tmr <= tmr - 32'h0000_0001;
                    end else begin
                        state <= S_IDLE;
                    end
                end
            endcase
            if (state == S_IDLE && cmd_valid) begin
                state <= S_ENABLE;
            end
        end
    end
    assign sensor_output_data_pin_out = (state == S_SEND) ? tx_line : 1'b0;
    // Half a bit of settling after release: a floating pin must not pass for an edge
    assign guard_done = !rx_armed && (rx_cnt == 16'h0000);
    // Supply stays up until the last ack cell is over
    assign ack_end = (state == S_RX) && (rx_n == 6'(ACK_BITS)) && (rx_cnt == 16'(HALF_BIT + HALF_BIT / 2));
    // Receiver: samples each bit three quarters in, after the mid-bit edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_d    <= 1'b0;
            rx_cnt   <= 16'h0000;
            rx_sh    <= '0;
            rx_n     <= 6'h00;
            rx_armed <= 1'b0;
        end else begin
            pin_d <= sensor_output_data_pin_in;
            if (state != S_RX && state != S_WAIT_NV) begin
                rx_n     <= 6'h00;
                rx_armed <= 1'b0;
                rx_cnt   <= 16'(HALF_BIT);
            end else if (!rx_armed) begin
                if (rx_cnt != 16'h0000) begin
                    rx_cnt <= rx_cnt - 16'h0001;
                end else if (state == S_RX && !pin_d && sensor_output_data_pin_in) begin
                    // Mid-bit rise of the first sync bit
                    rx_armed <= 1'b1;
                    rx_cnt   <= 16'(HALF_BIT / 2);
                end
            end else if (rx_cnt != 16'h0000) begin
                rx_cnt <= rx_cnt - 16'h0001;
            end else begin
                // Value in first half equals bit value
                rx_sh  <= {rx_sh[33:0], ~sensor_output_data_pin_in};  // [RQ16]
                rx_n   <= rx_n + 6'h01;
                rx_cnt <= 16'(2 * HALF_BIT - 1);
            end
        end
    end
    // Results: read fields split per acknowledge layout
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid   <= 1'b0;
            rsp_timeout <= 1'b0;
            rsp_data    <= 24'h00_0000;
            rsp_ecc     <= 2'h0;
            rsp_crc     <= 3'h0;
        end else begin
            rsp_valid   <= 1'b0;
            rsp_timeout <= 1'b0;
            if (ack_end) begin
                rsp_valid <= 1'b1;
                rsp_data  <= rx_sh[CRC_BITS +: PAYLOAD_BITS];            // [RQ13]
                rsp_ecc   <= rx_sh[CRC_BITS + ECC_LO +: 2];              // [RQ13]
                rsp_crc   <= rx_sh[CRC_BITS-1:0];
            end else if ((state == S_RX || state == S_WAIT_NV) && tmr == 32'h0000_0000) begin
                rsp_timeout <= 1'b1;
            end
        end
    end
    enable_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)    // [RQ3]
        (state == S_RELEASE) |=> !program_enable_high_level)
        else $error("enable not dropped after command");
    drive_low_a: assert property (@(posedge mclk) disable iff (!rst_n)    // [RQ2]
        $rose(program_enable_high_level) |-> sensor_output_data_pin_oe && !sensor_output_data_pin_out)
        else $error("line not driven low at enable");
    release_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)    // [RQ18]
        (state == S_RX) |-> !sensor_output_data_pin_oe)
        else $error("driving during acknowledge");
    one_frame_a: assert property (@(posedge mclk) disable iff (!rst_n)    // [RQ6]
        (state == S_RELEASE) |=> !tx_busy)
        else $error("frame during release");
    idle_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)    // [RQ3]
        (state == S_IDLE) |-> !sensor_output_data_pin_oe)
        else $error("pin driven while idle");
    commit_supply_a: assert property (@(posedge mclk) disable iff (!rst_n)    // [RQ4]
        (state == S_WAIT_NV) |-> program_enable_high_level && !sensor_output_data_pin_oe)
        else $error("supply or pin wrong during commit");
    cover_read_c:  cover property (@(posedge mclk) disable iff (!rst_n) rsp_valid);
    cover_nv_c:    cover property (@(posedge mclk) disable iff (!rst_n) state == S_WAIT_NV ##1 state == S_RELEASE);
    cover_write_c: cover property (@(posedge mclk) disable iff (!rst_n) kind == CMD_VOL_WR && state == S_RELEASE);
endmodule : prog_link_host

/* verif/sensor_dev_model.sv */
// Behavioural sensor as seen from its supply and data pins
`timescale 1ns/1ns
module sensor_dev_model #(
    parameter int         HALF_BIT = prog_link_pkg::HALF_BIT_CYC,
    parameter int         NV_CYC   = 1000,
    parameter logic [5:0] NV_LIMIT = 6'h10,
    parameter logic [1:0] ECC_ST   = 2'h1,
    parameter logic [2:0] ACK_CRC  = 3'h5
) (
    // Pins
    input  wire logic                                 mclk,
    input  wire logic                                 supply,
    input  wire logic                                 line,
    output logic                                      dev_oe,
    output logic                                      dev_out,
    // Scenario control and observation
    input  wire logic                                 mute,
    output logic [prog_link_pkg::FRAME_BITS-1:0]      frame,
    output logic [7:0]                                frame_count,
    output logic [15:0]                               low_wait
);
    import prog_link_pkg::*;
    localparam int H = HALF_BIT;
    logic [23:0]         mem [64];
    logic [ACK_BITS-1:0] ack;
    initial begin
        dev_oe = 1'b1; // Analog output live outside programming
        dev_out = 1'b1;
        frame_count = 8'h00;
        forever begin
            @(posedge supply);
            dev_oe <= 1'b0; // Pin turns into an input
            low_wait = 16'h0000;
            while (line !== 1'b0 && low_wait < 16'hFFFF) begin
                @(posedge mclk);
                low_wait++;
            end
            @(posedge line); // Mid edge of first sync bit; value is the first half
            frame = '0;
            for (int i = 1; i < FRAME_BITS; i++) begin
                repeat (H + H / 2) @(posedge mclk);
                frame[FRAME_BITS - 1 - i] = line;
                repeat (H / 2) @(posedge mclk);
            end
            frame_count++;
            repeat (H + 2) @(posedge mclk);
            // Payload only kept; CRC accepted unchecked since the polynomial is unknown
            // No frame is discarded: a CRC check needs the polynomial
            if (frame[39] == DIR_WR) begin
                mem[frame[38:33]] = frame[26:3];
                if (frame[38:33] < NV_LIMIT) begin
                    dev_oe <= 1'b1;
                    dev_out <= 1'b1;
                    repeat (NV_CYC) @(posedge mclk);
                    dev_out <= 1'b0; // Commit done edge
                end
            end else if (!mute) begin // Only reads are answered
                ack = {SYNC_VAL, 4'hA, ECC_ST, mem[frame[38:33]], ACK_CRC};
                repeat (H) @(posedge mclk);
                dev_oe <= 1'b1;
                for (int i = ACK_BITS - 1; i >= 0; i--) begin
                    dev_out <= ack[i];
                    repeat (H) @(posedge mclk);
                    dev_out <= ~ack[i];
                    repeat (H) @(posedge mclk);
                end
                if (supply) dev_oe <= 1'b0;
            end
            // Later pulses ignored until enable drops
            if (supply) @(negedge supply);
            dev_oe <= 1'b1;
            dev_out <= 1'b1;
        end
    end
endmodule : sensor_dev_model

/* verif/sensor_prog_serial_link_bench.sv */
// Self-checking bench for the programming link controller
`timescale 1ns/1ns
module sensor_prog_serial_link_bench;
    import prog_link_pkg::*;
    localparam int PD = 100;
    // Short bit cell keeps the run small; bit cells and the ack timeout scale with it, the 5000-cycle low delay does not
    localparam int HB = 20;
    logic        mclk, rstn, cmd_valid, cmd_ready, rsp_valid, rsp_timeout, pe, pin_out, pin_oe;
    logic        dev_oe, dev_out, mute, last;
    cmd_t        cmd_kind;
    logic [5:0]  cmd_addr;
    logic [23:0] cmd_data, rsp_data;
    logic [2:0]  cmd_crc, rsp_crc;
    logic [1:0]  rsp_ecc;
    logic [41:0] frame;
    logic [7:0]  frame_count;
    logic [15:0] low_wait;
    wire logic   line;
    int          mismatches, compares, n_valid, n_to;
    // Undriven line shows the inverse of its last level, never a stale match
    assign line = pin_oe ? pin_out : (dev_oe ? dev_out : ~last);
    always @(posedge mclk) if (pin_oe || dev_oe) last <= line;
    always @(posedge mclk) begin
        if (rsp_valid === 1'b1) n_valid++;
        if (rsp_timeout === 1'b1) n_to++;
    end
    prog_link_host #(.HALF_BIT(HB), .PROG_DELAY(PD), .WRITE_DELAY(4000)) u_dut (
        .mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_crc(cmd_crc), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_ecc(rsp_ecc), .rsp_crc(rsp_crc), .rsp_timeout(rsp_timeout),
        .program_enable_high_level(pe), .sensor_output_data_pin_in(line),
        .sensor_output_data_pin_out(pin_out), .sensor_output_data_pin_oe(pin_oe));
    sensor_dev_model #(.HALF_BIT(HB)) u_dev (
        .mclk(mclk), .supply(pe), .line(line), .dev_oe(dev_oe), .dev_out(dev_out), .mute(mute),
        .frame(frame), .frame_count(frame_count), .low_wait(low_wait));
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // One whole enable period: take, frame, wait for release
    task automatic run(input cmd_t k, input logic [5:0] a, input logic [23:0] d, input logic [2:0] c);
        int         n;
        logic [7:0] fc;
        fc = frame_count;
        n_valid = 0;
        n_to = 0;
        @(negedge mclk);
        while (cmd_ready !== 1'b1) @(negedge mclk);
        cmd_kind = k;
        cmd_addr = a;
        cmd_data = d;
        cmd_crc = c;
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        chk(pe, 1'b1);
        n = 0;
        while (pe !== 1'b0 && n < 20_000) begin
            @(negedge mclk);
            n++;
        end
        chk(pe, 1'b0);
        chk(pin_oe, 1'b0);
        chk(low_wait < PROG_DELAY_CYC, 1'b1);
        chk(frame_count, fc + 8'h01);
        chk(frame, {SYNC_VAL, (k == CMD_READ) ? DIR_RD : DIR_WR, a, 6'h00, d, c});
        repeat (PD + 10) @(negedge mclk);
    endtask : run
    task automatic t_reset();
        chk({pe, pin_oe, rsp_valid, cmd_ready}, 4'h1);
    endtask : t_reset
    task automatic t_writes();
        run(CMD_ACCESS, 6'h3F, 24'h5A0F_C3, 3'h2);
        run(CMD_VOL_WR, 6'h2A, 24'hA5C3_96, 3'h6);
        chk(n_valid + n_to, 0);
    endtask : t_writes
    task automatic t_read();
        run(CMD_READ, 6'h2A, 24'h0000_00, 3'h1);
        chk(n_valid, 1);
        chk({rsp_ecc, rsp_data, rsp_crc}, {2'h1, 24'hA5C3_96, 3'h5});
    endtask : t_read
    task automatic t_nv();
        run(CMD_NV_WR, 6'h05, 24'h1234_56, 3'h3);
        chk(n_to, 0);
        run(CMD_READ, 6'h05, 24'h0000_00, 3'h4);
        chk(rsp_data, 24'h1234_56);
    endtask : t_nv
    task automatic t_silent();
        mute = 1'b1;
        run(CMD_READ, 6'h2A, 24'h0000_00, 3'h7);
        chk({n_to[3:0], n_valid[3:0]}, 8'h10);
        mute = 1'b0;
    endtask : t_silent
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        repeat (80_000) @(posedge mclk);
        mismatches++;
        $display("Error at %0t: run did not finish", $time);
        close_out();
    end
    initial begin
        {rstn, cmd_valid, mute, last, cmd_addr, cmd_data, cmd_crc} = '0;
        cmd_kind = CMD_ACCESS;
        mismatches = 0;
        compares = 0;
        repeat (4) @(negedge mclk);
        rstn = 1'b1;
        repeat (4) @(negedge mclk);
        t_reset();
        t_writes();
        t_read();
        t_nv();
        t_silent();
        close_out();
    end
endmodule : sensor_prog_serial_link_bench
